// *** logic/itc_host.sv ***
// Port controller: Wishbone registers drive single byte-port cycles
`timescale 1ns/10ps
`default_nettype none
module itc_host (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Byte port to the timer
	itc_port_if.host         port
);
	import itc_pkg::*;

	// ****************************************
	// Bus slave
	// ****************************************
	itc_hstate_t state_r;
	logic [10:0] req_r;
	logic [7:0]  rdata_r;
	logic        ack_r, wr_r, rd_r;
	logic        bus_req, take_req;

	assign bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
	// Busy controller refuses new orders, so two-byte sequences stay unbroken
	assign take_req = bus_req && wb_we_i && wb_adr_i == ITC_REG_REQ
	                  && wb_sel_i[1:0] == 2'h3 && state_r == ITC_H_IDLE;

	// Ack one cycle after the request; unmapped reads return zero
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_r    <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_r <= bus_req;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					ITC_REG_REQ:  wb_dat_o <= {21'h000000, req_r};
					ITC_REG_STAT: wb_dat_o <= {16'h0000, rdata_r, 7'h00, state_r != ITC_H_IDLE};
					default:      wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_r;

	// ****************************************
	// Port sequencer
	// ****************************************

	// One strobe cycle per order, then wait for the timer's ack
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ITC_H_IDLE;
			req_r   <= 11'h000;
			rdata_r <= 8'h00;
			wr_r    <= 1'b0;
			rd_r    <= 1'b0;
		end else begin
			case (state_r)
				ITC_H_IDLE: begin
					if (take_req) begin
						req_r   <= wb_dat_i[10:0];
						wr_r    <= !wb_dat_i[ITC_REQ_RD];
						rd_r    <= wb_dat_i[ITC_REQ_RD];
						state_r <= ITC_H_WAIT;
					end
				end
				ITC_H_WAIT: begin
					wr_r <= 1'b0;
					rd_r <= 1'b0;
					if (port.ack) begin
						if (req_r[ITC_REQ_RD]) begin
							rdata_r <= port.rdata;
						end
						state_r <= ITC_H_IDLE;
					end
				end
				default: state_r <= ITC_H_IDLE;
			endcase
		end
	end

	// Order fields straight from the request register
	assign port.addr  = req_r[ITC_REQ_PORT+:2];
	assign port.wdata = req_r[ITC_REQ_DATA+:8];
	assign port.wr    = wr_r;
	assign port.rd    = rd_r;

endmodule
`default_nettype wire

// *** logic/itc_pkg.sv ***
// Shared constants and types for the three-channel interval timer
`default_nettype none
package itc_pkg;

	// ****************************************
	// Port map of the timer
	// ****************************************
	localparam int           ITC_NUM_CNT  = 3;
	localparam logic [1:0]   ITC_PORT_CMD = 2'h3;

	// ****************************************
	// Command byte fields
	// ****************************************
	localparam int           ITC_SEL_POS  = 6;
	localparam int           ITC_FMT_POS  = 4;
	localparam int           ITC_MODE_POS = 1;
	localparam int           ITC_BCD_POS  = 0;
	localparam logic [1:0]   ITC_SEL_BAD  = 2'h3;
	localparam logic [1:0]   ITC_FMT_LAT  = 2'h0;
	localparam logic [1:0]   ITC_FMT_LO   = 2'h1;
	localparam logic [1:0]   ITC_FMT_HI   = 2'h2;
	localparam logic [1:0]   ITC_FMT_WORD = 2'h3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0]  ITC_CNT_RST  = 16'h0000;
	localparam logic [1:0]   ITC_FMT_RST  = 2'h1;

	// ****************************************
	// Controller registers on the bus
	// ****************************************
	localparam logic [7:0]   ITC_REG_REQ  = 8'h00;
	localparam logic [7:0]   ITC_REG_STAT = 8'h04;
	localparam int           ITC_REQ_DATA = 0;
	localparam int           ITC_REQ_PORT = 8;
	localparam int           ITC_REQ_RD   = 10;
	localparam int           ITC_ST_BUSY  = 0;
	localparam int           ITC_ST_DATA  = 8;

	// Operating modes
	typedef enum logic [2:0] {
		ITC_M0,
		ITC_M1,
		ITC_M2,
		ITC_M3,
		ITC_M4,
		ITC_M5
	} itc_mode_t;

	// Controller sequencer
	typedef enum logic [0:0] {
		ITC_H_IDLE,
		ITC_H_WAIT
	} itc_hstate_t;

endpackage
`default_nettype wire

// *** logic/itc_port_if.sv ***
// Byte-wide port between controller and timer
`timescale 1ns/10ps
`default_nettype none
interface itc_port_if;
	logic [1:0] addr;
	logic       wr;
	logic       rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       ack;

	// Timer end
	modport dev (
		input  addr,
		input  wr,
		input  rd,
		input  wdata,
		output rdata,
		output ack
	);

	// Controller end
	modport host (
		output addr,
		output wr,
		output rd,
		output wdata,
		input  rdata,
		input  ack
	);
endinterface
`default_nettype wire

// *** logic/itc_timer.sv ***
// Three-channel interval timer, the device end of the port
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Mode 2 divides by N, one-clock low
// - Mode 2 rewrite waits for next period
// - Mode 2 gate low holds high, rise restarts
// - Mode 2 idle high until count written
// - Mode 3 even count steps by two
// - Mode 3 odd count subtracts one/three
// - Mode 4 counts after write, one-clock strobe
// - Mode 4 new count loads next clock
// - Mode 4 gate low suspends counting
// - Mode 5 trigger starts count, one-clock strobe
// - Mode 5 retrigger restarts full count
// - Host writes command before count
// - Count bytes follow chosen format
// - Count write leaves mode unchanged
// - Host keeps two-byte writes unbroken
// - Zero format field latches selected count
// - Latched value read low then high
// - Ports separate, commands act per counter
// - Format field: latch, low, high, both
// - Mode field decodes modes zero to five
// - Lowest command bit selects BCD counting
module itc_timer (
	// Clock and reset
	input  wire logic                            core_clk,
	input  wire logic                            rst_b,
	// Byte port from the controller
	itc_port_if.dev                              port,
	// Counter pins
	input  wire logic [itc_pkg::ITC_NUM_CNT-1:0] cnt_clk,
	input  wire logic [itc_pkg::ITC_NUM_CNT-1:0] cnt_gate,
	output logic      [itc_pkg::ITC_NUM_CNT-1:0] cnt_out
);
	import itc_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************

	// Subtract 1..3 in binary or four-digit BCD; zero wraps to full scale
	function automatic logic [15:0] itc_sub(input logic [15:0] v, input logic [1:0] n, input logic bcd);
		logic [15:0] r;
		logic [4:0]  d;
		logic [1:0]  take;
		r = 16'h0000;
		d = 5'h00;
		take = n;
		if (!bcd) begin
			r = v - {14'h0000, n};
		end else begin
			for (int k = 0; k < 4; k++) begin
				d = {1'b0, v[4*k+:4]} - {3'h0, take};
				if (d[4]) begin
					d = d + 5'h0a;
					take = 2'h1;
				end else begin
					take = 2'h0;
				end
				r[4*k+:4] = d[3:0];
			end
		end
		return r;
	endfunction

	// Mode field decode, bit 2 ignored for modes 2 and 3
	function automatic itc_mode_t itc_decode(input logic [2:0] m);
		itc_mode_t r;
		r = ITC_M0;
		casez (m)
			3'b000: r = ITC_M0;
			3'b001: r = ITC_M1;
			3'b?10: r = ITC_M2;
			3'b?11: r = ITC_M3;
			3'b100: r = ITC_M4;
			3'b101: r = ITC_M5;
			default: r = ITC_M0;
		endcase
		return r;
	endfunction

	// ****************************************
	// Pin synchronisers and edge detect
	// ****************************************
	logic [ITC_NUM_CNT-1:0] clk_s1_r, clk_s2_r, clk_s3_r;
	logic [ITC_NUM_CNT-1:0] gate_s1_r, gate_s2_r, gate_s3_r;
	logic [ITC_NUM_CNT-1:0] tick, gate_rise;

	// Counter pins are asynchronous, two flops before use
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_s1_r  <= '0;
			clk_s2_r  <= '0;
			clk_s3_r  <= '0;
			gate_s1_r <= '1; // Idle-high gate gives no false rise
			gate_s2_r <= '1;
			gate_s3_r <= '1;
		end else begin
			clk_s1_r  <= cnt_clk;
			clk_s2_r  <= clk_s1_r;
			clk_s3_r  <= clk_s2_r;
			gate_s1_r <= cnt_gate;
			gate_s2_r <= gate_s1_r;
			gate_s3_r <= gate_s2_r;
		end
	end

	// Count on the falling edge of each counter clock
	assign tick      = clk_s3_r & ~clk_s2_r;
	assign gate_rise = gate_s2_r & ~gate_s3_r;

	// ****************************************
	// Port answer
	// ****************************************
	logic [ITC_NUM_CNT-1:0][7:0] rd_byte;
	logic [7:0]                  rdata_r;
	logic                        ack_r;

	// One-cycle ack after each strobe; command port reads as zero
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_r   <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			ack_r <= port.wr | port.rd;
			if (port.rd) begin
				rdata_r <= (port.addr == ITC_PORT_CMD) ? 8'h00 : rd_byte[port.addr];
			end
		end
	end

	assign port.ack   = ack_r;
	assign port.rdata = rdata_r;

	// ****************************************
	// Counters
	// ****************************************
	for (genvar i = 0; i < ITC_NUM_CNT; i++) begin : g_cnt
		itc_mode_t   mode_r;
		logic [1:0]  fmt_r;
		logic        bcd_r;
		logic [15:0] cr_r, ce_r, lat_r;
		logic        wr_hi_r, rd_hi_r, latched_r;
		logic        armed_r, load_r, trig_r, run_r, out_r;
		logic        cmd_hit, is_latch, cmd_prog, data_wr, data_rd, done_wr;
		logic        start, gate;
		logic [1:0]  step;
		logic [15:0] show;

		// Command acts only on the counter it names
		assign cmd_hit  = port.wr && port.addr == ITC_PORT_CMD
		                  && port.wdata[ITC_SEL_POS+:2] == 2'(i);
		assign is_latch = port.wdata[ITC_FMT_POS+:2] == ITC_FMT_LAT;
		assign cmd_prog = cmd_hit && !is_latch;
		assign data_wr  = port.wr && port.addr == 2'(i);
		assign data_rd  = port.rd && port.addr == 2'(i);
		assign done_wr  = data_wr && (fmt_r != ITC_FMT_WORD || wr_hi_r);
		assign gate     = gate_s2_r[i];
		assign start    = armed_r && (trig_r || (load_r && !run_r));
		// Odd count: one off in high phase, three off in low phase
		assign step     = !ce_r[0] ? 2'h2 : (out_r ? 2'h1 : 2'h3);

		// Mode, format and arithmetic held until the next command
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				mode_r <= ITC_M0;
				fmt_r  <= ITC_FMT_RST;
				bcd_r  <= 1'b0;
			end else if (cmd_prog) begin
				mode_r <= itc_decode(port.wdata[ITC_MODE_POS+:3]);
				fmt_r  <= port.wdata[ITC_FMT_POS+:2];
				bcd_r  <= port.wdata[ITC_BCD_POS];
			end
		end

		// Count register assembly; a count write never touches the mode
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				cr_r    <= ITC_CNT_RST;
				wr_hi_r <= 1'b0;
			end else if (cmd_prog) begin
				wr_hi_r <= 1'b0;
			end else if (data_wr) begin
				case (fmt_r)
					ITC_FMT_LO: cr_r <= {8'h00, port.wdata};
					ITC_FMT_HI: cr_r <= {port.wdata, 8'h00};
					ITC_FMT_WORD: begin
						if (wr_hi_r) begin
							cr_r[15:8] <= port.wdata;
						end else begin
							cr_r[7:0] <= port.wdata;
						end
						wr_hi_r <= ~wr_hi_r;
					end
					default: cr_r <= cr_r;
				endcase
			end
		end

		// Output latch freezes the count until readout finishes
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				lat_r     <= ITC_CNT_RST;
				latched_r <= 1'b0;
				rd_hi_r   <= 1'b0;
			end else if (cmd_prog) begin
				latched_r <= 1'b0;
				rd_hi_r   <= 1'b0;
			end else if (cmd_hit && !latched_r) begin
				lat_r     <= ce_r;
				latched_r <= 1'b1;
			end else if (data_rd) begin
				if (fmt_r == ITC_FMT_WORD && !rd_hi_r) begin
					rd_hi_r <= 1'b1;
				end else begin
					rd_hi_r   <= 1'b0;
					latched_r <= 1'b0;
				end
			end
		end

		// Read byte follows the format and the read order
		assign show       = latched_r ? lat_r : ce_r;
		assign rd_byte[i] = (fmt_r == ITC_FMT_HI || (fmt_r == ITC_FMT_WORD && rd_hi_r))
		                    ? show[15:8] : show[7:0];

		// Counting element and output, one step per counter tick
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				ce_r    <= ITC_CNT_RST;
				out_r   <= 1'b1;
				armed_r <= 1'b0;
				load_r  <= 1'b0;
				trig_r  <= 1'b0;
				run_r   <= 1'b0;
			end else if (cmd_prog) begin
				// Mode set: idle, mode 0 low, all others high
				out_r   <= itc_decode(port.wdata[ITC_MODE_POS+:3]) != ITC_M0;
				armed_r <= 1'b0;
				load_r  <= 1'b0;
				trig_r  <= 1'b0;
				run_r   <= 1'b0;
			end else begin
				// A write or trigger landing on a tick is never lost
				if (done_wr) begin
					armed_r <= 1'b1;
					load_r  <= 1'b1;
				end else if (tick[i] && (start || mode_r == ITC_M0 || mode_r == ITC_M4)) begin
					load_r <= 1'b0;
				end
				if (gate_rise[i]) begin
					trig_r <= 1'b1;
				end else if (tick[i]) begin
					trig_r <= 1'b0;
				end
				if ((mode_r == ITC_M2 || mode_r == ITC_M3) && !gate) begin
					out_r <= 1'b1;
				end else if (tick[i]) begin
					case (mode_r)
						ITC_M0, ITC_M4: begin
							if (load_r) begin
								ce_r  <= cr_r;
								run_r <= 1'b1;
							end else if (run_r && gate) begin
								ce_r <= itc_sub(ce_r, 2'h1, bcd_r);
								if (mode_r == ITC_M4) begin
									out_r <= ce_r != 16'h0001;
									run_r <= ce_r != 16'h0001;
								end else if (ce_r == 16'h0001) begin
									out_r <= 1'b1;
								end
							end else if (mode_r == ITC_M4) begin
								out_r <= 1'b1;
							end
						end
						ITC_M1, ITC_M5: begin
							if (trig_r && armed_r) begin
								ce_r  <= cr_r;
								run_r <= 1'b1;
								out_r <= mode_r == ITC_M5;
							end else if (run_r) begin
								ce_r  <= itc_sub(ce_r, 2'h1, bcd_r);
								run_r <= ce_r != 16'h0001;
								out_r <= (mode_r == ITC_M5) ? ce_r != 16'h0001 : ce_r == 16'h0001;
							end else begin
								out_r <= 1'b1;
							end
						end
						ITC_M2: begin
							if (start) begin
								ce_r  <= cr_r;
								run_r <= 1'b1;
								out_r <= 1'b1;
							end else if (run_r) begin
								// Reload only at the end of a period
								if (ce_r == 16'h0001) begin
									ce_r  <= cr_r;
									out_r <= 1'b1;
								end else begin
									ce_r  <= itc_sub(ce_r, 2'h1, bcd_r);
									out_r <= ce_r != 16'h0002;
								end
							end
						end
						ITC_M3: begin
							if (start) begin
								ce_r  <= cr_r;
								run_r <= 1'b1;
								out_r <= 1'b1;
							end else if (run_r) begin
								if (ce_r == {14'h0000, step}) begin
									ce_r  <= cr_r;
									out_r <= ~out_r;
								end else begin
									ce_r <= itc_sub(ce_r, step, bcd_r);
								end
							end
						end
						default: out_r <= 1'b1;
					endcase
				end
			end
		end

		assign cnt_out[i] = out_r;
	end

endmodule
`default_nettype wire

// *** tb/itc_port_asserts.sv ***
// Handshake checks on the byte port between controller and timer
`timescale 1ns/10ps
`default_nettype none
module itc_port_asserts (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Byte port
	input  wire logic [1:0] addr,
	input  wire logic       wr,
	input  wire logic       rd,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] rdata,
	input  wire logic       ack
);
	import itc_pkg::*;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// ********
	// Strobe and answer
	// ********
	// Every strobe gets exactly one answer, one cycle later
	strobe_ack_a: assert property ((wr || rd) |=> ack ##1 !ack)
		else $error("byte port answer missing or long");
	ack_cause_a: assert property (ack |-> $past(wr || rd))
		else $error("byte port answer without strobe");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("byte port answer longer than one cycle");
	// One transfer in flight keeps two-byte counts unbroken
	one_flight_a: assert property ((wr || rd) |=> !(wr || rd))
		else $error("strobe while a transfer is in flight");
	no_overlap_a: assert property (ack |-> !(wr || rd))
		else $error("strobe in the answer cycle");
	dir_excl_a: assert property (!(wr && rd))
		else $error("read and write strobes together");

	// ********
	// Read data
	// ********
	// Read data only moves in answer to a read
	rdata_hold_a: assert property (!$past(rd) |-> $stable(rdata))
		else $error("read data moved without a read");
	cmd_read_a: assert property ((rd && addr == ITC_PORT_CMD) |=> rdata == 8'h00)
		else $error("command port read not zero");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the interval timer and its controller
`timescale 1ns/10ps
`default_nettype none
module tb;
	import itc_pkg::*;

	// ********
	// Signals
	// ********
	logic        core_clk    = 1'b0;
	logic        rst_b       = 1'b0;
	logic        wb_cyc      = 1'b0;
	logic        wb_stb      = 1'b0;
	logic        wb_we       = 1'b0;
	logic [7:0]  wb_adr      = 8'h00;
	logic [3:0]  wb_sel      = 4'hf;
	logic [31:0] wb_wdat     = 32'h0;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic [2:0]  cnt_clk     = 3'h7;
	logic [2:0]  cnt_gate    = 3'h7;
	logic [2:0]  cnt_out;
	logic [2:0]  div         = 3'h0;
	logic [31:0] q;
	logic [15:0] lows;
	logic [15:0] run;
	int          n_mismatch  = 0;
	int          check_count = 0;
	int          cyc         = 0;

	itc_port_if port_if ();
	itc_host itc_host_i (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .port(port_if));
	itc_timer itc_timer_i (.core_clk(core_clk), .rst_b(rst_b), .port(port_if),
		.cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out));
	itc_port_asserts itc_port_asserts_i (.core_clk(core_clk), .rst_b(rst_b), .addr(port_if.addr),
		.wr(port_if.wr), .rd(port_if.rd), .wdata(port_if.wdata), .rdata(port_if.rdata),
		.ack(port_if.ack));

	always #12.5 core_clk = ~core_clk;

	// Counter clock: four core cycles each phase, twice the sync minimum
	always @(posedge core_clk) begin
		div <= div + 3'h1;
		cnt_clk <= {3{div[2]}};
	end

	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// ********
	// Shared tasks
	// ********
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; the request stands until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack !== 1'b1);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		// Registered ack answers at the second edge
		chk(16'(n), 16'd2);
	endtask

	// One byte-port transfer, then poll until the controller is idle
	task automatic order(input logic [1:0] p, input logic [7:0] b, input logic r);
		wb(1'b1, ITC_REG_REQ, {21'h0, r, p, b});
		do begin
			wb(1'b0, ITC_REG_STAT, 32'h0);
		end while (q[ITC_ST_BUSY] !== 1'b0);
	endtask

	// Samples an output once per counter tick, mid high phase
	task automatic meas(input int ch, input int n);
		logic [15:0] r;
		lows = 16'h0;
		run = 16'h0;
		r = 16'h0;
		repeat (n) begin
			@(posedge core_clk iff div == 3'd5);
			if (cnt_out[ch] !== 1'b1) begin
				lows++;
				r++;
				run = (r > run) ? r : run;
			end else r = 16'h0;
		end
	endtask

	task automatic trig(input int ch);
		cnt_gate[ch] <= 1'b0;
		repeat (4) @(posedge core_clk);
		cnt_gate[ch] <= 1'b1;
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_regs;
		wb(1'b0, 8'h08, 32'h0);
		chk(q[15:0], 16'h0000);
		order(ITC_PORT_CMD, 8'h00, 1'b1);
		chk({8'h00, q[15:8]}, 16'h0000);
		wb(1'b0, ITC_REG_REQ, 32'h0);
		chk(q[15:0], 16'h0700);
	endtask

	// Counter 0 as rate generator, mode bits 110
	task automatic t_rate;
		order(ITC_PORT_CMD, 8'h1c, 1'b0);
		meas(0, 8);
		chk(lows, 16'd0);
		order(2'h0, 8'h05, 1'b0);
		meas(0, 4);
		meas(0, 20);
		chk(lows, 16'd4);
		chk(run, 16'd1);
		order(2'h0, 8'h04, 1'b0);
		meas(0, 6);
		meas(0, 20);
		chk(lows, 16'd5);
		cnt_gate[0] <= 1'b0;
		meas(0, 8);
		chk(lows, 16'd0);
		cnt_gate[0] <= 1'b1;
		// Restart loads the full count: first low on the fourth tick
		meas(0, 3);
		chk(lows, 16'd0);
		meas(0, 1);
		chk(lows, 16'd1);
		meas(0, 20);
		chk(lows, 16'd5);
		order(ITC_PORT_CMD, 8'h15, 1'b0);
		order(2'h0, 8'h10, 1'b0);
		meas(0, 12);
		meas(0, 30);
		chk(lows, 16'd3);
	endtask

	// Counter 1 square wave, word format, other counter's command between bytes
	task automatic t_square;
		order(ITC_PORT_CMD, 8'h7e, 1'b0);
		order(2'h1, 8'h06, 1'b0);
		order(ITC_PORT_CMD, 8'h1c, 1'b0);
		order(2'h1, 8'h00, 1'b0);
		meas(1, 6);
		meas(1, 24);
		chk(lows, 16'd12);
		chk(run, 16'd3);
		order(2'h1, 8'h07, 1'b0);
		order(2'h1, 8'h00, 1'b0);
		meas(1, 10);
		meas(1, 28);
		chk(lows, 16'd12);
		chk(run, 16'd3);
	endtask

	// Counter 1 retriggerable strobe
	task automatic t_trig;
		order(ITC_PORT_CMD, 8'h5a, 1'b0);
		order(2'h1, 8'h06, 1'b0);
		meas(1, 10);
		chk(lows, 16'd0);
		repeat (4) begin
			trig(1);
			meas(1, 4);
			chk(lows, 16'd0);
		end
		meas(1, 6);
		chk(lows, 16'd1);
	endtask

	// Counter 2 software strobe
	task automatic t_strobe;
		order(ITC_PORT_CMD, 8'h98, 1'b0);
		meas(2, 6);
		chk(lows, 16'd0);
		order(2'h2, 8'h06, 1'b0);
		meas(2, 12);
		chk(lows, 16'd1);
		chk(run, 16'd1);
		order(2'h2, 8'h0a, 1'b0);
		meas(2, 3);
		order(2'h2, 8'h03, 1'b0);
		meas(2, 5);
		chk(lows, 16'd1);
		meas(2, 10);
		chk(lows, 16'd0);
		cnt_gate[2] <= 1'b0;
		order(2'h2, 8'h04, 1'b0);
		meas(2, 10);
		chk(lows, 16'd0);
		cnt_gate[2] <= 1'b1;
		meas(2, 8);
		chk(lows, 16'd1);
	endtask

	// Frozen count is latched, then released count runs before readout
	task automatic t_latch;
		cnt_gate[2] <= 1'b0;
		// High-byte-only count reads back live; a counter-3 command is dropped
		order(ITC_PORT_CMD, 8'ha8, 1'b0);
		order(2'h2, 8'h12, 1'b0);
		meas(2, 2);
		order(ITC_PORT_CMD, 8'hd6, 1'b0);
		order(2'h2, 8'h00, 1'b1);
		chk({8'h00, q[15:8]}, 16'h0012);
		order(ITC_PORT_CMD, 8'hb8, 1'b0);
		order(2'h2, 8'h34, 1'b0);
		order(2'h2, 8'h12, 1'b0);
		meas(2, 3);
		order(ITC_PORT_CMD, 8'h8f, 1'b0);
		cnt_gate[2] <= 1'b1;
		meas(2, 4);
		order(ITC_PORT_CMD, 8'h80, 1'b0);
		order(2'h2, 8'h00, 1'b1);
		chk({8'h00, q[15:8]}, 16'h0034);
		order(2'h2, 8'h00, 1'b1);
		chk({8'h00, q[15:8]}, 16'h0012);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk({13'h0, cnt_out}, 16'h0007);
		t_regs();
		t_rate();
		t_square();
		t_trig();
		t_strobe();
		t_latch();
		finish_test();
	end
endmodule
`default_nettype wire
